/* File: src/atomic_store_alias_pkg.sv */
/*
  Constants, field layouts and carrier types for the atomic
  store-without-return decoder. Assumes a single 20 MHz clock domain.
*/
package atomic_store_alias_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] INSTR_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RESULT_LO_OFS = 8'h0C;
  localparam logic [7:0] RESULT_HI_OFS = 8'h10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Control and status bit positions
  localparam int unsigned CTRL_CAP_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_UNDEF_BIT = 2;
  localparam int unsigned ST_REL_BIT = 3;
  localparam int unsigned ST_CAP_BIT = 4;

  // Instruction field layout
  localparam int unsigned SIZE_HI = 31;
  localparam int unsigned SIZE_LO = 30;
  localparam int unsigned FIX_HI = 29;
  localparam int unsigned FIX_LO = 24;
  localparam int unsigned ACQ_BIT = 23;
  localparam int unsigned REL_BIT = 22;
  localparam int unsigned ONE_BIT = 21;
  localparam int unsigned SRC_HI = 20;
  localparam int unsigned SRC_LO = 16;
  localparam int unsigned O3_BIT = 15;
  localparam int unsigned OPC_HI = 14;
  localparam int unsigned OPC_LO = 12;
  localparam int unsigned ZERO_HI = 11;
  localparam int unsigned ZERO_LO = 10;
  localparam int unsigned BASE_HI = 9;
  localparam int unsigned BASE_LO = 5;
  localparam int unsigned DST_HI = 4;
  localparam int unsigned DST_LO = 0;

  localparam logic [5:0] FIX_VAL = 6'h38;
  localparam logic [2:0] OPC_SET = 3'h3;
  localparam logic [2:0] OPC_SMAX = 3'h4;
  localparam logic [4:0] ZERO_REG = 5'h1F;
  localparam logic [4:0] SP_REG = 5'h1F;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_DWORD = 2'h3
  } size_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPS = 3'h1,
    ST_READ = 3'h3,
    ST_WRITE = 3'h2
  } state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic lock;
    logic release_ord;
    size_t size;
    logic [63:0] addr;
    logic [63:0] wdata;
  } mem_req_t;

  typedef struct packed {
    state_t state;
    logic cap_flag;
    logic [31:0] instr;
    logic [63:0] src;
    logic [63:0] result;
    logic done;
    logic undef;
    logic cap_used;
    mem_req_t mem;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
  } blk_state_t;

endpackage

/* File: src/atomic_store_alias_decode.sv */
/*
  Decoder and sequencer for atomic store-without-return forms: halfword
  OR, and signed maximum on byte, halfword, word and doubleword.
  Software writes an instruction word over AHB-Lite; the block fetches
  its operands from the register file ports and runs a locked
  read-modify-write on the memory port. Assumes the register file
  answers combinationally and the memory keeps the lock atomic.
*/
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
module atomic_store_alias_decode
  import atomic_store_alias_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [4:0] src_idx_o,
  input wire logic [63:0] src_data_i,
  output logic [4:0] base_idx_o,
  output logic base_is_sp_o,
  output logic base_cap_o,
  input wire logic [63:0] base_addr_i,
  output mem_req_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [63:0] mem_rdata_i
);

  blk_state_t st_r;
  blk_state_t st_nxt;

  logic [4:0] f_dst;
  logic [4:0] f_src;
  logic [4:0] f_base;
  logic [2:0] f_opc;
  size_t f_size;
  logic f_form_ok;
  logic f_legal;
  logic take;
  logic [63:0] mem_sx;
  logic [63:0] src_sx;
  logic [63:0] combined;
  logic [63:0] src_sel;
  logic busy;

  // Sign-extend the low bytes of a value to 64 bits by access size
  function automatic logic [63:0] sext(input logic [63:0] v,
                                       input size_t sz);
    logic [63:0] r;
    r = v;
    case (sz)
      SZ_BYTE: r = {{56{v[7]}}, v[7:0]};
      SZ_HALF: r = {{48{v[15]}}, v[15:0]};
      SZ_WORD: r = {{32{v[31]}}, v[31:0]};
      SZ_DWORD: r = v;
      default: r = v;
    endcase
    return r;
  endfunction

  // Clear bits above the access size so memory sees clean data
  function automatic logic [63:0] trunc(input logic [63:0] v,
                                        input size_t sz);
    logic [63:0] r;
    r = v;
    case (sz)
      SZ_BYTE: r = {56'h0, v[7:0]};
      SZ_HALF: r = {48'h0, v[15:0]};
      SZ_WORD: r = {32'h0, v[31:0]};
      SZ_DWORD: r = v;
      default: r = v;
    endcase
    return r;
  endfunction

  // Fields of the held instruction
  assign f_dst = st_r.instr[DST_HI:DST_LO];
  assign f_src = st_r.instr[SRC_HI:SRC_LO];
  assign f_base = st_r.instr[BASE_HI:BASE_LO];
  assign f_opc = st_r.instr[OPC_HI:OPC_LO];
  assign f_size = size_t'(st_r.instr[SIZE_HI:SIZE_LO]);

  // Only the load-atomic pattern with acquire clear and o3 clear
  assign f_form_ok = st_r.instr[FIX_HI:FIX_LO] == FIX_VAL
                     && !st_r.instr[ACQ_BIT]
                     && st_r.instr[ONE_BIT]
                     && !st_r.instr[O3_BIT]
                     && st_r.instr[ZERO_HI:ZERO_LO] == 2'h0;

  // Store alias only when the destination is the zero register
  always_comb
  begin
    f_legal = 1'b0;
    if (f_form_ok && f_dst == ZERO_REG)
    begin
      if (f_opc == OPC_SMAX)
        f_legal = 1'b1;
      else if (f_opc == OPC_SET && f_size == SZ_HALF)
        f_legal = 1'b1;
    end
  end

  // Source register view: 32-bit forms use the W register
  assign src_sel = (f_size == SZ_DWORD) ? src_data_i
                                        : {32'h0, src_data_i[31:0]};

  assign mem_sx = sext(mem_rdata_i, st_r.mem.size);
  assign src_sx = sext(st_r.src, st_r.mem.size);

  always_comb
  begin
    combined = trunc(mem_rdata_i, st_r.mem.size);
    if (f_opc == OPC_SET)
      combined = trunc(mem_rdata_i | st_r.src, SZ_HALF);
    else if ($signed(src_sx) > $signed(mem_sx))
      combined = trunc(st_r.src, st_r.mem.size);
  end

  assign busy = st_r.state != ST_IDLE;
  assign take = hsel_i && htrans_i[1] && hready_i;

  always_comb
  begin
    st_nxt = st_r;
    // AHB data phase: writes land now, read data was staged
    if (st_r.dp_write)
    begin
      case (st_r.dp_addr)
        CTRL_OFS: st_nxt.cap_flag = hwdata_i[CTRL_CAP_BIT];
        INSTR_OFS:
        begin
          // A new instruction while one runs is dropped
          if (!busy)
          begin
            st_nxt.instr = hwdata_i;
            st_nxt.done = 1'b0;
            st_nxt.undef = 1'b0;
            st_nxt.state = ST_OPS;
          end
        end
        default: st_nxt.cap_flag = st_r.cap_flag;
      endcase
    end
    st_nxt.dp_write = take && hwrite_i;
    st_nxt.dp_addr = haddr_i[7:0];
    if (take && !hwrite_i)
    begin
      case (haddr_i[7:0])
        CTRL_OFS: st_nxt.hrdata = {31'h0, st_r.cap_flag};
        INSTR_OFS: st_nxt.hrdata = st_r.instr;
        STATUS_OFS: st_nxt.hrdata = {27'h0, st_r.cap_used,
                                     st_r.instr[REL_BIT], st_r.undef,
                                     st_r.done, busy};
        RESULT_LO_OFS: st_nxt.hrdata = st_r.result[31:0];
        RESULT_HI_OFS: st_nxt.hrdata = st_r.result[63:32];
        default: st_nxt.hrdata = 32'h0;
      endcase
    end

    case (st_r.state)
      ST_IDLE:
      begin
        st_nxt.mem.req = 1'b0;
        st_nxt.mem.lock = 1'b0;
      end
      ST_OPS:
      begin
        if (!f_legal)
        begin
          st_nxt.undef = 1'b1;
          st_nxt.done = 1'b1;
          st_nxt.state = ST_IDLE;
        end
        else
        begin
          st_nxt.src = src_sel;
          st_nxt.cap_used = st_r.cap_flag;
          st_nxt.mem.addr = base_addr_i;
          st_nxt.mem.size = f_size;
          st_nxt.mem.req = 1'b1;
          st_nxt.mem.we = 1'b0;
          st_nxt.mem.lock = 1'b1;
          st_nxt.mem.release_ord = 1'b0;
          st_nxt.state = ST_READ;
        end
      end
      ST_READ:
      begin
        if (mem_ack_i)
        begin
          // Lock stays up so the write follows the read unbroken
          st_nxt.mem.we = 1'b1;
          st_nxt.mem.wdata = combined;
          st_nxt.result = combined;
          st_nxt.mem.release_ord = st_r.instr[REL_BIT];
          st_nxt.state = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        if (mem_ack_i)
        begin
          // Old value is discarded: no register writeback
          st_nxt.mem.req = 1'b0;
          st_nxt.mem.we = 1'b0;
          st_nxt.mem.lock = 1'b0;
          st_nxt.mem.release_ord = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.state = ST_IDLE;
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.cap_flag <= CTRL_RST[CTRL_CAP_BIT];
      st_r.state <= ST_IDLE;
    end
    else if (ce_i)
      st_r <= st_nxt;
  end

  // Register file read ports, valid while operands are fetched
  assign src_idx_o = f_src;
  assign base_idx_o = f_base;
  assign base_is_sp_o = f_base == SP_REG;
  assign base_cap_o = st_r.cap_flag;

  assign mem_o = st_r.mem;
  assign hrdata_o = st_r.hrdata;
  // Zero-wait slave; stalls are never needed
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

endmodule

/* File: tb/atomic_store_alias_props.sv */
/*
  Port checker for the atomic store decoder.
  Assumes one clock, async active-high reset, bound to every instance.
*/
`timescale 1ns/1ns
module atomic_store_alias_props
  import atomic_store_alias_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [4:0] base_idx_o,
  input wire logic base_is_sp_o,
  input wire logic [63:0] base_addr_i,
  input wire mem_req_t mem_o,
  input wire logic mem_ack_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Address must be the base value seen while operands were fetched
  property p_sp;
    $rose(mem_o.req) |-> mem_o.addr == $past(base_addr_i);
  endproperty
  a_sp: assert property (p_sp)
    else $error("access address is not the base register value");
  property p_rd_first;
    $rose(mem_o.req) |-> !mem_o.we && mem_o.lock;
  endproperty
  a_rd_first: assert property (p_rd_first)
    else $error("access did not open with locked read");
  property p_wr;
    ce_i && mem_o.req && !mem_o.we && mem_ack_i
      |=> mem_o.req && mem_o.we && mem_o.lock;
  endproperty
  a_wr: assert property (p_wr)
    else $error("no locked write after read");
  property p_same;
    $rose(mem_o.we) |-> $past(mem_o.req) &&
      mem_o.addr == $past(mem_o.addr) && mem_o.size == $past(mem_o.size);
  endproperty
  a_same: assert property (p_same)
    else $error("write went to another place");
  property p_hold;
    ce_i && mem_o.req && !mem_ack_i |=> $stable(mem_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  property p_rd_rel;
    mem_o.req && !mem_o.we |-> !mem_o.release_ord;
  endproperty
  a_rd_rel: assert property (p_rd_rel)
    else $error("ordering on read part");
  property p_idle;
    !mem_o.req |-> !mem_o.we && !mem_o.release_ord && !mem_o.lock;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle port not quiet");
  property p_end;
    ce_i && mem_o.req && mem_o.we && mem_ack_i |=> !mem_o.req;
  endproperty
  a_end: assert property (p_end)
    else $error("request kept after write ack");
endmodule
bind atomic_store_alias_decode atomic_store_alias_props u_props (
  .sys_clk_i, .rst_i, .ce_i, .base_idx_o, .base_is_sp_o, .base_addr_i,
  .mem_o, .mem_ack_i);

/* File: tb/atomic_mem_model.sv */
/*
  One-location memory partner; ack after dly_i idle cycles.
  Assumes the bench loads store directly before each operation.
*/
`timescale 1ns/1ns
module atomic_mem_model
  import atomic_store_alias_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire mem_req_t mem_i,
  input wire logic [1:0] dly_i,
  output logic ack_o,
  output logic [63:0] rdata_o
);
  logic [63:0] store;
  logic [63:0] last_addr;
  logic last_rel;
  logic [1:0] last_size;
  logic [1:0] cnt;
  int wr_cnt = 0;
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      ack_o <= 1'h0;
      cnt <= 2'h0;
      rdata_o <= 64'h0;
    end
    else if (mem_i.req && !ack_o && cnt == dly_i)
    begin
      ack_o <= 1'h1;
      cnt <= 2'h0;
      rdata_o <= store;
      if (mem_i.we)
      begin
        store <= mem_i.wdata;
        last_addr <= mem_i.addr;
        last_rel <= mem_i.release_ord;
        last_size <= mem_i.size;
        wr_cnt <= wr_cnt + 1;
      end
    end
    else
    begin
      ack_o <= 1'h0;
      cnt <= (mem_i.req && !ack_o) ? cnt + 2'h1 : 2'h0;
      // Stale data must not look valid
      rdata_o <= ~rdata_o;
    end
endmodule

/* File: tb/atomic_store_alias_decode_tb_top.sv */
/*
  Bench: AHB-Lite tasks and a table of atomic operations.
  Assumes zero-wait slave; register file answered here combinationally.
*/
`timescale 1ns/1ns
module atomic_store_alias_decode_tb_top;
  import atomic_store_alias_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, hsel = 0, hwrite = 0, ack;
  logic hrdy, hresp, sp, cap;
  logic [1:0] htrans = 0, dly = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [4:0] sidx, bidx, exp_rs = 0;
  logic [63:0] sval = 0, rdata, base, sdat;
  mem_req_t mreq;
  logic [4:0] dst = ZERO_REG;
  int err_count = 0, tests_run = 0;
  assign sdat = (sidx == exp_rs) ? sval : ~sval;
  assign base = {cap, sp, 57'h0, bidx};
  initial forever #25 sys_clk_i = ~sys_clk_i;
  atomic_store_alias_decode dut (.sys_clk_i, .rst_i, .ce_i(1'h1),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .src_idx_o(sidx),
    .src_data_i(sdat), .base_idx_o(bidx), .base_is_sp_o(sp),
    .base_cap_o(cap), .base_addr_i(base), .mem_o(mreq), .mem_ack_i(ack),
    .mem_rdata_i(rdata));
  atomic_mem_model mem (.sys_clk_i, .rst_i, .mem_i(mreq), .dly_i(dly),
    .ack_o(ack), .rdata_o(rdata));
  task tally_and_finish;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [63:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task rdy;
    int k;
    k = 0;
    @(posedge sys_clk_i);
    while (hrdy !== 1'h1)
    begin
      k++;
      if (k > 50)
      begin
        err_count++;
        tally_and_finish;
      end
      @(posedge sys_clk_i);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  function automatic logic [63:0] calc(input logic [2:0] o,
    input logic [1:0] z, input logic [63:0] m, s);
    int sh;
    logic [63:0] r;
    sh = 64 - (8 << z);
    if (o == OPC_SET)
      r = m | s;
    else
      r = ($signed(m << sh) > $signed(s << sh)) ? m : s;
    return r & (~64'h0 >> sh);
  endfunction
  task op(input logic [1:0] z, input logic r, input logic [2:0] o,
    input logic [4:0] rs, rn, input logic c, input logic [63:0] m, s,
    input logic u);
    int k, w0;
    logic [63:0] mk;
    logic [31:0] lo;
    mk = ~64'h0 >> (64 - (8 << z));
    ahb(1'h1, CTRL_OFS, {31'h0, c});
    mem.store <= m;
    sval <= s;
    exp_rs <= rs;
    dly <= rs[1:0];
    w0 = mem.wr_cnt;
    ahb(1'h1, INSTR_OFS,
      {z, FIX_VAL, 1'h0, r, 1'h1, rs, 1'h0, o, 2'h0, rn, dst});
    k = 0;
    q = 32'h0;
    while (q[ST_DONE_BIT] !== 1'h1 && k < 40)
    begin
      ahb(1'h0, STATUS_OFS, 32'h0);
      k++;
    end
    chk("timeout", 0, k == 40);
    if (k == 40)
      tally_and_finish;
    chk("undef", u, q[ST_UNDEF_BIT]);
    chk("cap", c, q[ST_CAP_BIT]);
    chk("rel", r, q[ST_REL_BIT]);
    if (u)
      chk("writes", w0, mem.wr_cnt);
    else
    begin
      chk("data", calc(o, z, m, s), mem.store & mk);
      chk("addr", {c, rn == SP_REG, 57'h0, rn}, mem.last_addr);
      chk("order", r, mem.last_rel);
      chk("size", z, mem.last_size);
      ahb(1'h0, RESULT_LO_OFS, 32'h0);
      lo = q;
      ahb(1'h0, RESULT_HI_OFS, 32'h0);
      chk("result", calc(o, z, m, s), {q, lo});
    end
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    @(posedge sys_clk_i);
    ahb(1'h0, CTRL_OFS, 32'h0);
    chk("ctrl", CTRL_RST, q);
    ahb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 0, q);
    chk("hresp", 0, hresp);
    op(2'h1, 0, OPC_SET, 5'h03, 5'h02, 0, 64'hF0F0, 64'h0F01, 0);
    op(2'h1, 1, OPC_SET, 5'h1E, 5'h1F, 1, 64'h8000, 64'h1, 0);
    op(2'h0, 0, OPC_SMAX, 5'h04, 5'h01, 0, 64'h80, 64'h05, 0);
    op(2'h0, 1, OPC_SMAX, 5'h05, 5'h07, 1, 64'h7F, 64'hFF, 0);
    op(2'h1, 1, OPC_SMAX, 5'h06, 5'h1F, 0, 64'hFFFE, 64'h3, 0);
    op(2'h2, 0, OPC_SMAX, 5'h07, 5'h09, 1, 64'h8000_0000,
      64'hFFFF_FFFF_0000_0001, 0);
    op(2'h3, 1, OPC_SMAX, 5'h00, 5'h0A, 0, 64'hFFFF_FFFF_0000_0005,
      64'h2, 0);
    op(2'h2, 0, OPC_SET, 5'h01, 5'h02, 0, 64'h0, 64'h0, 1);
    // Destination other than the zero register is no store alias
    dst = 5'h03;
    op(2'h1, 0, OPC_SET, 5'h02, 5'h04, 0, 64'h1, 64'h2, 1);
    tally_and_finish;
  end
endmodule
